// file: logic/fpdt_ctrl.sv
// host-side controller for a fast page mode dram module
//
// What this block does
// - after reset wait over 100 us, then eight refreshes before any access
// - refresh every row within 32 ms, spread evenly
// - consecutive page column cycles no closer than 40, 45 or 50 ns
// - row strobe low no longer than 125,000 ns per activation
// - column strobe high at least 10 ns between page cycles
// - row strobe stays low 35/40/45 ns after column precharge starts
// - row address held 10 ns, or 12 ns at 80 ns grade, after row strobe falls
// - column address held at least 15 ns after column strobe falls
// - column address present 30/35/40 ns before row strobe rises
// - read: write strobe high no later than column strobe fall
// - read: write strobe stays high until column or row strobe rises
// - early write: write strobe low no later than column strobe fall
// - refresh: column strobe falls at least 10 ns before row strobe
// - row to column strobe delay at least 20 ns, 25 ns at 80 ns grade
// - 2,048 refreshes per period, column-before-row refresh used
// - row then column multiplexed over eleven address pins
`timescale 1ns/10ps
`include "fpdt_consts.svh"
module fpdt_ctrl import fpdt_pkg::*; #(
  parameter int unsigned PAGE_MAX_CYC = `FPDT_CYC_MAX(`FPDT_PAGE_ROW_ACTIVE_MAX_NS)
) (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // configuration strap
  input  wire logic [1:0]                  grade_i,
  // request stream
  input  wire logic                        req_valid_i,
  output logic                             req_ready_o,
  input  wire logic                        req_write_i,
  input  wire logic [`FPDT_ADDR_W-1:0]     req_addr_i,
  input  wire logic [`FPDT_DATA_W-1:0]     req_data_i,
  // read answers and status
  output logic                             rd_valid_o,
  output logic [`FPDT_DATA_W-1:0]          rd_data_o,
  output logic                             init_done_o,
  // dram pins
  output logic [`FPDT_PIN_ADDR_W-1:0]      mem_addr_o,
  output logic                             row_strobe_n_o,
  output logic [3:0]                       col_strobe_n_o,
  output logic                             write_n_o,
  input  wire logic [`FPDT_DATA_W-1:0]     mem_data_i,
  output logic [`FPDT_DATA_W-1:0]          mem_data_o,
  output logic                             mem_data_oe_n_o
);
  localparam int unsigned FW = 1 + `FPDT_ADDR_W + `FPDT_DATA_W;
  // strictly more than the power-up wait
  localparam logic [12:0] INIT_CYC = 13'(`FPDT_CYC_MAX(`FPDT_POWERUP_WAIT_NS) + 1);
  localparam logic [9:0]  REF_INT_CYC =
    10'(`FPDT_CYC_MAX(`FPDT_REFRESH_PERIOD_NS / `FPDT_REFRESH_ROWS));
  localparam logic [12:0] PAGE_LIMIT = 13'(PAGE_MAX_CYC - `FPDT_PAGE_GUARD_CYC);

  // cycle count of a minimum time for the fitted grade
  function automatic logic [7:0] pick(input fpdt_grade_t g, input int unsigned a,
                                      input int unsigned b, input int unsigned c);
    unique case (g)
      FPDT_G60: pick = 8'(`FPDT_CYC_MIN(a));
      FPDT_G70: pick = 8'(`FPDT_CYC_MIN(b));
      default:  pick = 8'(`FPDT_CYC_MIN(c));
    endcase
  endfunction

  logic [1:0]                grade_s1_q, grade_s2_q;
  logic [`FPDT_DATA_W-1:0]   din_s1_q, din_s2_q;
  fpdt_grade_t               grade_q, grade_d;
  fpdt_state_t               state_q, state_d;
  logic [7:0]                cnt_q, cnt_d;
  logic [12:0]               up_q, up_d, page_tmr_q, page_tmr_d;
  logic [9:0]                ref_tmr_q, ref_tmr_d;
  logic                      ref_pend_q, ref_pend_d, ref_clr;
  logic [3:0]                init_left_q, init_left_d;
  logic [`FPDT_PIN_ADDR_W-1:0] row_q, row_d, col_q, col_d, addr_q, addr_d;
  logic                      wr_q, wr_d, ras_n_q, ras_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
  logic [3:0]                cas_n_q, cas_n_d;
  logic [`FPDT_DATA_W-1:0]   wdat_q, wdat_d, rdat_q, rdat_d;
  logic                      rdv_q, rdv_d, done_q, done_d;
  logic                      head_valid, pop;
  logic [FW-1:0]             head;
  logic                      h_wr;
  logic [`FPDT_ADDR_W-1:0]   h_addr;
  logic [`FPDT_DATA_W-1:0]   h_data;
  logic                      need_ref;

  fpdt_fifo #(.WIDTH(FW), .DEPTH(`FPDT_FIFO_DEPTH)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   ({req_write_i, req_addr_i, req_data_i}),
    .out_valid_o (head_valid),
    .out_ready_i (pop),
    .out_data_o  (head)
  );

  assign {h_wr, h_addr, h_data} = head;

  // strap and data pins cross in through two flops
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      grade_s1_q <= 2'h0;
      grade_s2_q <= 2'h0;
      din_s1_q   <= '0;
      din_s2_q   <= '0;
    end else begin
      grade_s1_q <= grade_i;
      grade_s2_q <= grade_s1_q;
      din_s1_q   <= mem_data_i;
      din_s2_q   <= din_s1_q;
    end
  end

  always_comb begin
    state_d     = state_q;
    cnt_d       = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
    grade_d     = grade_q;
    up_d        = up_q;
    page_tmr_d  = ras_n_q ? 13'h0000 : page_tmr_q + 13'h0001;
    ref_tmr_d   = (ref_tmr_q == 10'h000) ? REF_INT_CYC - 10'h001 : ref_tmr_q - 10'h001;
    ref_clr     = 1'b0;
    init_left_d = init_left_q;
    row_d       = row_q;
    col_d       = col_q;
    addr_d      = addr_q;
    wr_d        = wr_q;
    wdat_d      = wdat_q;
    ras_n_d     = ras_n_q;
    cas_n_d     = cas_n_q;
    we_n_d      = we_n_q;
    oe_n_d      = oe_n_q;
    rdat_d      = rdat_q;
    rdv_d       = 1'b0;
    pop         = 1'b0;
    need_ref    = ref_pend_q || (init_left_q != 4'h0);
    unique case (state_q)
      ST_POWER: begin
        // strap is static; keep tracking it until the wait is over
        grade_d = (grade_s2_q == 2'h0) ? FPDT_G60 :
                  (grade_s2_q == 2'h1) ? FPDT_G70 : FPDT_G80;
        up_d = up_q + 13'h0001;
        if (up_q == INIT_CYC) begin
          init_left_d = `FPDT_INIT_REFRESHES;
          state_d     = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (need_ref) begin
          cas_n_d = 4'h0;
          cnt_d   = pick(grade_q, `FPDT_REFRESH_COL_LEAD_MIN) - 8'h01;
          state_d = ST_RCAS;
        end else if (head_valid) begin
          pop     = 1'b1;
          row_d   = h_addr[`FPDT_ROW_MSB:`FPDT_ROW_LSB];
          col_d   = h_addr[`FPDT_COL_MSB:0];
          wr_d    = h_wr;
          wdat_d  = h_data;
          addr_d  = h_addr[`FPDT_ROW_MSB:`FPDT_ROW_LSB];
          ras_n_d = 1'b0;
          cnt_d   = pick(grade_q, `FPDT_ROW_ADDR_HOLD_MIN) - 8'h01;
          state_d = ST_ROW;
        end
      end
      ST_ROW: begin
        if (cnt_q == 8'h00) begin
          addr_d  = col_q;
          we_n_d  = ~wr_q;
          oe_n_d  = ~wr_q;
          state_d = ST_COL;
        end
      end
      ST_COL: begin
        cas_n_d = 4'h0;
        cnt_d   = pick(grade_q, `FPDT_COL_ADDR_ACCESS_MAX) + 8'(`FPDT_SYNC_STAGES) - 8'h01;
        state_d = ST_CAS;
      end
      ST_CAS: begin
        if (cnt_q == 8'h00) begin
          cas_n_d = 4'hF;
          oe_n_d  = 1'b1;
          rdv_d   = ~wr_q;
          rdat_d  = din_s2_q;
          cnt_d   = pick(grade_q, `FPDT_ROW_HOLD_AFTER_CP) - 8'h01;
          state_d = ST_CPRE;
        end
      end
      ST_CPRE: begin
        // stay in the page only for the same row, with room before the row time runs out
        if (!need_ref && head_valid && h_addr[`FPDT_ROW_MSB:`FPDT_ROW_LSB] == row_q &&
            page_tmr_q < PAGE_LIMIT) begin
          pop     = 1'b1;
          wr_d    = h_wr;
          wdat_d  = h_data;
          addr_d  = h_addr[`FPDT_COL_MSB:0];
          we_n_d  = ~h_wr;
          oe_n_d  = ~h_wr;
          state_d = ST_COL;
        end else begin
          state_d = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (cnt_q == 8'h00) begin
          ras_n_d = 1'b1;
          we_n_d  = 1'b1;
          cnt_d   = pick(grade_q, `FPDT_ROW_PRECHARGE_MIN) - 8'h01;
          state_d = ST_RPRE;
        end
      end
      ST_RPRE: begin
        if (cnt_q == 8'h00) begin
          state_d = ST_IDLE;
        end
      end
      ST_RCAS: begin
        if (cnt_q == 8'h00) begin
          ras_n_d = 1'b0;
          ref_clr = 1'b1;
          if (init_left_q != 4'h0) begin
            init_left_d = init_left_q - 4'h1;
          end
          cnt_d   = pick(grade_q, `FPDT_ROW_ACTIVE_MIN) - 8'h01;
          state_d = ST_RRAS;
        end
      end
      ST_RRAS: begin
        if (cnt_q == 8'h00) begin
          ras_n_d = 1'b1;
          cas_n_d = 4'hF;
          cnt_d   = pick(grade_q, `FPDT_ROW_PRECHARGE_MIN) - 8'h01;
          state_d = ST_RPRE;
        end
      end
    endcase
    // a new tick wins over a refresh being issued in the same cycle
    ref_pend_d = (ref_tmr_q == 10'h000) || (ref_pend_q && !ref_clr);
    done_d     = (state_q != ST_POWER) && (init_left_d == 4'h0);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_POWER;
      cnt_q       <= 8'h00;
      grade_q     <= FPDT_G80;
      up_q        <= 13'h0000;
      page_tmr_q  <= 13'h0000;
      ref_tmr_q   <= 10'h000;
      ref_pend_q  <= 1'b0;
      init_left_q <= 4'h0;
      row_q       <= '0;
      col_q       <= '0;
      addr_q      <= '0;
      wr_q        <= 1'b0;
      wdat_q      <= '0;
      ras_n_q     <= 1'b1;
      cas_n_q     <= 4'hF;
      we_n_q      <= 1'b1;
      oe_n_q      <= 1'b1;
      rdat_q      <= '0;
      rdv_q       <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      grade_q     <= grade_d;
      up_q        <= up_d;
      page_tmr_q  <= page_tmr_d;
      ref_tmr_q   <= ref_tmr_d;
      ref_pend_q  <= ref_pend_d;
      init_left_q <= init_left_d;
      row_q       <= row_d;
      col_q       <= col_d;
      addr_q      <= addr_d;
      wr_q        <= wr_d;
      wdat_q      <= wdat_d;
      ras_n_q     <= ras_n_d;
      cas_n_q     <= cas_n_d;
      we_n_q      <= we_n_d;
      oe_n_q      <= oe_n_d;
      rdat_q      <= rdat_d;
      rdv_q       <= rdv_d;
      done_q      <= done_d;
    end
  end

  assign mem_addr_o      = addr_q;
  assign row_strobe_n_o  = ras_n_q;
  assign col_strobe_n_o  = cas_n_q;
  assign write_n_o       = we_n_q;
  assign mem_data_o      = wdat_q;
  assign mem_data_oe_n_o = oe_n_q;
  assign rd_valid_o      = rdv_q;
  assign rd_data_o       = rdat_q;
  assign init_done_o     = done_q;

  // helper counters watched only by the checks below
  logic [13:0] since_ref_q;
  logic [7:0]  since_cas_q;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_ref_q <= 14'h0000;
      since_cas_q <= 8'h00;
    end else begin
      since_ref_q <= ($fell(ras_n_q) && cas_n_q == 4'h0) ? 14'h0000 :
                     (since_ref_q == 14'h3FFF) ? since_ref_q : since_ref_q + 14'h0001;
      since_cas_q <= ($fell(cas_n_q[0])) ? 8'h00 :
                     (since_cas_q == 8'hFF) ? since_cas_q : since_cas_q + 8'h01;
    end
  end

  AST_INIT_WAIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(ras_n_q) |-> up_q > INIT_CYC) else $error("row strobe before power-up wait");
  AST_REF_SPACING: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    init_done_o |-> since_ref_q <= 14'(REF_INT_CYC) + 14'(PAGE_MAX_CYC))
    else $error("refresh spacing exceeded");
  AST_PAGE_CYCLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(cas_n_q[0]) && !ras_n_q && $past(!ras_n_q, 3) |-> $past(since_cas_q) >= 8'h01)
    else $error("page cycle too short");
  AST_PAGE_MAX: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    page_tmr_q < 13'(PAGE_MAX_CYC)) else $error("row active too long");
  AST_CAS_PRECHARGE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(cas_n_q[0]) |=> cas_n_q[0]) else $error("column precharge too short");
  AST_RHCP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(cas_n_q[0]) && !ras_n_q |=> !ras_n_q) else $error("row rose too soon");
  // the row goes out on the edge that lowers the strobe; it must still stand one edge later
  AST_ROW_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(ras_n_q) && cas_n_q == 4'hF |-> mem_addr_o == row_q) else $error("row address hold");
  AST_COL_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(cas_n_q[0]) && !ras_n_q |=> $stable(mem_addr_o)) else $error("column address hold");
  AST_COL_LEAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(ras_n_q) && $past(cas_n_q, 2) == 4'hF |-> $past(mem_addr_o) == $past(mem_addr_o, 2))
    else $error("column address lead");
  AST_WE_SETUP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(cas_n_q[0]) && !ras_n_q |-> $stable(write_n_o)) else $error("write strobe setup");
  AST_READ_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !cas_n_q[0] && !ras_n_q && write_n_o |=> write_n_o || cas_n_q[0])
    else $error("read hold broken");
  AST_EARLY_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(cas_n_q[0]) && !write_n_o |-> $past(!write_n_o) && !mem_data_oe_n_o)
    else $error("early write setup");
  AST_CBR_LEAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(ras_n_q) && cas_n_q == 4'h0 |-> $past(cas_n_q) == 4'h0)
    else $error("refresh column lead");
  AST_RCD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(cas_n_q[0]) && !ras_n_q |-> $past(!ras_n_q, 2)) else $error("row to column delay");
endmodule // fpdt_ctrl

// file: logic/fpdt_consts.svh
// timing and layout constants for the fast page dram controller
`ifndef FPDT_CONSTS_SVH
`define FPDT_CONSTS_SVH

`define FPDT_CLK_NS                 25
`define FPDT_CYC_MIN(ns)            (((ns) + `FPDT_CLK_NS - 1) / `FPDT_CLK_NS)
`define FPDT_CYC_MAX(ns)            ((ns) / `FPDT_CLK_NS)

`define FPDT_POWERUP_WAIT_NS        100000
`define FPDT_INIT_REFRESHES         4'h8
`define FPDT_REFRESH_PERIOD_NS      32000000
`define FPDT_REFRESH_ROWS           2048
`define FPDT_PAGE_ROW_ACTIVE_MAX_NS 125000
`define FPDT_PAGE_GUARD_CYC         16

// per grade: 60, 70, 80 ns
`define FPDT_ROW_ADDR_HOLD_MIN      10, 10, 12
`define FPDT_COL_ADDR_ACCESS_MAX    30, 35, 40
`define FPDT_ROW_HOLD_AFTER_CP      35, 40, 45
`define FPDT_PAGE_CYCLE_MIN         40, 45, 50
`define FPDT_ROW_PRECHARGE_MIN      40, 50, 60
`define FPDT_ROW_ACTIVE_MIN         60, 70, 80
`define FPDT_REFRESH_COL_LEAD_MIN   10, 10, 10

`define FPDT_SYNC_STAGES            2
`define FPDT_ADDR_W                 22
`define FPDT_PIN_ADDR_W             11
`define FPDT_DATA_W                 36
`define FPDT_FIFO_DEPTH             32
`define FPDT_ROW_MSB                21
`define FPDT_ROW_LSB                11
`define FPDT_COL_MSB                10

`endif

// file: logic/fpdt_pkg.sv
// types for the fast page dram controller
package fpdt_pkg;
  typedef enum logic [1:0] {FPDT_G60, FPDT_G70, FPDT_G80} fpdt_grade_t;
  typedef enum logic [3:0] {
    ST_POWER, ST_IDLE, ST_ROW, ST_COL, ST_CAS, ST_CPRE, ST_CLOSE, ST_RPRE, ST_RCAS, ST_RRAS
  } fpdt_state_t;
endpackage

// file: logic/fpdt_fifo.sv
// request fifo, flip-flop storage, registered full and empty
`timescale 1ns/10ps
module fpdt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [CW-1:0]    count_q, count_d;
  logic             ready_q, ready_d, valid_q, valid_d, push, pop;

  always_comb begin
    push     = in_valid_i && ready_q;
    pop      = out_ready_i && valid_q;
    wr_ptr_d = push ? AW'((wr_ptr_q + 1'b1) % DEPTH) : wr_ptr_q;
    rd_ptr_d = pop ? AW'((rd_ptr_q + 1'b1) % DEPTH) : rd_ptr_q;
    count_d  = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
    ready_d = count_d != CW'(DEPTH);
    valid_d = count_d != '0;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b1;
      valid_q  <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      ready_q  <= ready_d;
      valid_q  <= valid_d;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  assign in_ready_o  = ready_q;
  assign out_valid_o = valid_q;
  assign out_data_o  = mem_q[rd_ptr_q];
endmodule // fpdt_fifo

// file: dv/fpdt_dram_model.sv
// behavioural fast page dram module as seen at the controller pins
`timescale 1ns/10ps
module fpdt_dram_model #(
  parameter int unsigned PAGE_MAX_CYC = 64
) (
  // power-up marker
  input  wire logic        pwr_rst_i,
  // dram pins
  input  wire logic [10:0] addr_i,
  input  wire logic        row_strobe_n_i,
  input  wire logic [3:0]  col_strobe_n_i,
  input  wire logic        write_n_i,
  input  wire logic [35:0] dq_i,
  output logic [35:0]      dq_o,
  // timing faults seen
  output logic [7:0]       fault_o
);
  logic [35:0] mem [logic [21:0]];
  logic [10:0] row_q;
  logic [21:0] key;
  logic        rd_q;
  bit          fast;
  realtime     t_pwr, t_ras, t_cas, t_cup, t_ref;
  int          refs;

  initial begin
    dq_o = '0;
    fault_o = '0;
    rd_q = 1'b0;
    refs = 0;
  end

  function automatic void flag();
    fault_o = fault_o + 8'h01;
  endfunction

  // a controller reset stands for a fresh power-up
  always @(negedge pwr_rst_i) begin
    refs = 0;
    t_pwr = $realtime;
  end

  always @(negedge row_strobe_n_i) begin
    t_ras = $realtime;
    if (col_strobe_n_i[0] === 1'b0) begin
      if (t_ras - t_cas < 10.0) flag();
      if (refs >= 8 && t_ras - t_ref > 15625.0 + PAGE_MAX_CYC * 25.0) flag();
      t_ref = t_ras;
      refs++;
    end else begin
      row_q = addr_i;
      if (refs < 8 || t_ras - t_pwr <= 100000.0) flag();
    end
  end

  always @(posedge row_strobe_n_i)
    if ($realtime - t_ras > PAGE_MAX_CYC * 25.0) flag();

  always @(negedge col_strobe_n_i[0]) begin
    t_cas = $realtime;
    if (col_strobe_n_i !== 4'h0) flag();
    if (row_strobe_n_i === 1'b0) begin
      if (t_cas - t_cup < 10.0 || t_cas - t_ras < 20.0) flag();
      key = {row_q, addr_i};
      rd_q = write_n_i;
      if (write_n_i === 1'b0) begin
        mem[key] = dq_i;
      end else begin
        // alternate prompt and slow answers, both inside the access limits
        fast = !fast;
        #(fast ? 1.0 : 5.0);
        if (col_strobe_n_i[0] === 1'b0) dq_o = mem.exists(key) ? mem[key] : '0;
      end
    end
  end

  always @(posedge col_strobe_n_i[0]) begin
    t_cup = $realtime;
    if (rd_q === 1'b1 && write_n_i !== 1'b1) flag();
    rd_q = 1'b0;
    // released pins must not keep showing the last word
    #5.0;
    dq_o = ~dq_o;
  end
endmodule // fpdt_dram_model

// file: dv/testbench.sv
// self-checking bench for the fast page dram controller
`timescale 1ns/10ps
module testbench;
  localparam int unsigned PMAX = 64;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [1:0]  grade_i = 2'h0;
  logic        req_valid_i = 1'b0;
  logic        req_write_i = 1'b0;
  logic [21:0] req_addr_i = 22'h000000;
  logic [35:0] req_data_i = 36'h000000000;
  logic        req_ready_o, rd_valid_o, init_done_o, row_strobe_n_o, write_n_o;
  logic [35:0] rd_data_o, mem_data_o, dq_model;
  logic [10:0] mem_addr_o;
  logic [3:0]  col_strobe_n_o;
  logic        mem_data_oe_n_o;
  logic [7:0]  fault;
  wire  [35:0] mem_bus;
  int          seed, mismatches, n_checks, cyc, t0, g, i, k;
  logic [35:0] shadow [logic [21:0]];
  logic [35:0] expq [$];
  logic [21:0] wq [$];

  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  assign mem_bus = (mem_data_oe_n_o === 1'b0) ? mem_data_o : dq_model;

  fpdt_ctrl #(.PAGE_MAX_CYC(PMAX)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .grade_i(grade_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_data_i(req_data_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .init_done_o(init_done_o), .mem_addr_o(mem_addr_o),
    .row_strobe_n_o(row_strobe_n_o), .col_strobe_n_o(col_strobe_n_o), .write_n_o(write_n_o),
    .mem_data_i(mem_bus), .mem_data_o(mem_data_o), .mem_data_oe_n_o(mem_data_oe_n_o));

  fpdt_dram_model #(.PAGE_MAX_CYC(PMAX)) model_u (
    .pwr_rst_i(rst_i), .addr_i(mem_addr_o), .row_strobe_n_i(row_strobe_n_o),
    .col_strobe_n_i(col_strobe_n_o), .write_n_i(write_n_o), .dq_i(mem_bus),
    .dq_o(dq_model), .fault_o(fault));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  function automatic logic [21:0] addr_of(input int r, input int c);
    return {r[10:0], c[10:0]};
  endfunction

  function automatic logic [35:0] rnd36();
    return {4'($random(seed)), 32'($random(seed))};
  endfunction

  // request held until the edge that sees ready high
  task automatic push(input logic wr, input logic [21:0] a, input logic [35:0] d);
    int  n;
    logic rdy;
    #2;
    req_valid_i = 1'b1;
    req_write_i = wr;
    req_addr_i = a;
    req_data_i = d;
    rdy = req_ready_o;
    n = 0;
    @(posedge sys_clk_i);
    while (rdy !== 1'b1) begin
      n++;
      if (n > 8000) begin
        chk(1'b0, "request never taken");
        end_of_test();
      end
      #2;
      rdy = req_ready_o;
      @(posedge sys_clk_i);
    end
    if (wr) begin
      shadow[a] = d;
      wq.push_back(a);
    end else expq.push_back(shadow[a]);
  endtask

  always @(negedge sys_clk_i)
    if (rd_valid_o === 1'b1) begin
      if (expq.size() == 0) chk(1'b0, "read answer without request");
      else chk(rd_data_o === expq.pop_front(), "read data");
    end

  initial begin
    seed = 32'h676C37FB;
    for (g = 0; g < 4; g++) begin
      #2;
      rst_i = 1'b1;
      grade_i = g[1:0];
      repeat (2) @(posedge sys_clk_i);
      #2;
      rst_i = 1'b0;
      t0 = cyc;
      wq.delete();
      @(posedge sys_clk_i);
      // queue fills while the controller is still in its power-up wait
      for (i = 0; i < 32; i++) push(1'b1, addr_of(g + i / 16, 11'h7C0 + i * 5 + ($random(seed) & 3)), rnd36());
      @(negedge sys_clk_i);
      chk(req_ready_o === 1'b0, "full queue still ready");
      k = 0;
      while (init_done_o !== 1'b1) begin
        @(negedge sys_clk_i);
        k++;
        if (k > 6000) begin
          chk(1'b0, "init never done");
          end_of_test();
        end
      end
      chk(cyc - t0 > 4001, "init done too early");
      @(posedge sys_clk_i);
      // long same-row runs force page mode and the page length limit
      for (i = 0; i < 32; i++) push(1'b0, wq[i], 36'h000000000);
      for (i = 0; i < 40; i++)
        if ($random(seed) & 1) push(1'b1, addr_of(5 + ($random(seed) & 1), $random(seed) & 15), rnd36());
        else push(1'b0, wq[{$random(seed)} % wq.size()], 36'h000000000);
      #2;
      req_valid_i = 1'b0;
      k = 0;
      while (expq.size() != 0) begin
        @(posedge sys_clk_i);
        k++;
        if (k > 20000) begin
          chk(1'b0, "reads never answered");
          end_of_test();
        end
      end
      // idle long enough for refreshes at rest
      repeat (1400) @(posedge sys_clk_i);
    end
    chk(fault === 8'h00, "pin timing fault seen by the memory");
    end_of_test();
  end
endmodule // testbench
